/* File: rtl/eeprom_spi_cfg.svh */
// constants of the serial configuration memory port
`ifndef EEPROM_SPI_CFG_SVH
`define EEPROM_SPI_CFG_SVH

// ----------------------------------------
// frame layout
// ----------------------------------------
`define FRAME_BITS      16
`define FRAME_EDGES     5'h10
`define EDGE_CNT_MAX    5'h1F
`define ADDR_LSB        0
`define ADDR_MSB        2
`define DATA_LSB        4
`define DATA_MSB        10
`define CMD_LSB         11
`define CMD_MSB         12
`define READY_BIT       13
`define ERR_BIT         14
`define PAR_BIT         15

// ----------------------------------------
// memory timing
// ----------------------------------------
`define CLK_PERIOD_NS   10
`define MEM_READ_NS     10000
`define MEM_WRITE_NS    5000000
`define MEM_READ_CYC    ((`MEM_READ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MEM_WRITE_CYC   ((`MEM_WRITE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMER_W         20

// ----------------------------------------
// reset values
// ----------------------------------------
`define MEM_RESET       56'h00_0000_0000_0000

`endif

/* File: rtl/eeprom_spi_frame_access.sv */
// serial frame access to the configuration memory
`include "eeprom_spi_cfg.svh"

module eeprom_spi_frame_access #(
	parameter int unsigned     READ_CYC  = `MEM_READ_CYC,
	parameter int unsigned     WRITE_CYC = `MEM_WRITE_CYC,
	parameter logic [55:0]     MEM_INIT  = `MEM_RESET
) (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          rst_b,
	// mode from the device's mode logic
	input  wire logic          serial_mode,
	input  wire logic          enable_pin,
	// shared pins
	input  wire logic          low_side_input_two,
	input  wire logic          low_side_input_three,
	input  wire logic          fault_comm_input,
	output logic               low_side_input_one_o,
	output logic               low_side_input_one_oe,
	output logic               fault_comm_line_o,
	output logic               fault_comm_line_oe,
	// working registers
	output logic [55:0]        work_regs,
	output logic               reload_busy
);

	localparam logic [19:0] RD_LEN = 20'(READ_CYC);
	localparam logic [19:0] WR_LEN = 20'(WRITE_CYC);

	eeprom_spi_pkg::port_state_t st_ff;
	eeprom_spi_pkg::port_state_t nxt_st;

	nvm_timer_if tif ();

	// ----------------------------------------
	// memory action timer
	// ----------------------------------------
	nvm_timer u_timer (
		.clk   (clk),
		.rst_b (rst_b),
		.tif   (tif)
	);

	assign tif.start  = st_ff.start;
	assign tif.length = st_ff.length;

	// ----------------------------------------
	// edge detection and frame decode
	// ----------------------------------------
	logic              sclk_rise;
	logic              sel_fall;
	logic              sel_rise;
	logic              en_rise;
	logic              port_on;
	logic              par_ok;
	logic              frame_err;
	logic [1:0]        cmd;
	logic              is_write;
	logic [2:0]        addr;
	logic [6:0]        wdata;
	logic [15:0]       resp;

	always_comb begin
		sclk_rise = st_ff.sclk_s2 & ~st_ff.sclk_s3;
		sel_fall  = ~st_ff.sel_b_s2 & st_ff.sel_b_s3;
		sel_rise  = st_ff.sel_b_s2 & ~st_ff.sel_b_s3;
		en_rise   = st_ff.en_s2 & ~st_ff.en_s3;
		port_on   = serial_mode & (st_ff.state == eeprom_spi_pkg::ST_SERIAL);
		// odd parity over the command, address and data field
		par_ok    = st_ff.in_sr[`PAR_BIT] == ~(^st_ff.in_sr[`CMD_MSB:0]);
		frame_err = ~par_ok | (st_ff.edge_cnt != `FRAME_EDGES);
		cmd       = st_ff.in_sr[`CMD_MSB:`CMD_LSB];
		is_write  = cmd == eeprom_spi_pkg::MEMORY_WRITE_CMD;
		addr      = st_ff.in_sr[`ADDR_MSB:`ADDR_LSB];
		wdata     = st_ff.in_sr[`DATA_MSB:`DATA_LSB];
		resp      = 16'h0000;
		resp[`ADDR_MSB:`ADDR_LSB] = addr;
		resp[`CMD_MSB:`CMD_LSB]   = cmd;
		if (is_write) begin
			resp[`DATA_MSB:`DATA_LSB] = wdata;
		end else begin
			resp[`DATA_MSB:`DATA_LSB] = st_ff.mem[addr];
		end
		resp[`ERR_BIT]   = frame_err;
		resp[`READY_BIT] = 1'b0;
		resp[`PAR_BIT]   = ~(^resp[`ERR_BIT:0]);
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		nxt_st          = st_ff;
		nxt_st.start    = 1'b0;
		// two-stage synchronisers, third stage for edges
		nxt_st.sclk_s1  = low_side_input_two;
		nxt_st.sclk_s2  = st_ff.sclk_s1;
		nxt_st.sclk_s3  = st_ff.sclk_s2;
		nxt_st.mosi_s1  = low_side_input_three;
		nxt_st.mosi_s2  = st_ff.mosi_s1;
		nxt_st.sel_b_s1 = fault_comm_input;
		nxt_st.sel_b_s2 = st_ff.sel_b_s1;
		nxt_st.sel_b_s3 = st_ff.sel_b_s2;
		nxt_st.en_s1    = enable_pin;
		nxt_st.en_s2    = st_ff.en_s1;
		nxt_st.en_s3    = st_ff.en_s2;
		nxt_st.miso_oe  = port_on & ~st_ff.sel_b_s2;

		// memory action finished
		if (tif.done) begin
			if (st_ff.pend_wr) begin
				nxt_st.mem[st_ff.pend_addr] = st_ff.pend_data;
			end
			nxt_st.pend_wr = 1'b0;
			// ready only if select is high when the action finishes
			if (st_ff.sel_b_s2 && port_on) begin
				nxt_st.ready                = 1'b1;
				nxt_st.out_sr[`READY_BIT]   = 1'b1;
				nxt_st.out_sr[`PAR_BIT]     = ~st_ff.out_sr[`PAR_BIT];
			end
		end

		case (st_ff.state)
			eeprom_spi_pkg::ST_SERIAL: begin
				if (en_rise) begin
					nxt_st.state = eeprom_spi_pkg::ST_RELOAD;
				end else if (port_on) begin
					if (sel_fall) begin
						nxt_st.edge_cnt = 5'h00;
						nxt_st.ready    = 1'b0;
						nxt_st.miso     = st_ff.out_sr[0];
					end else if (sel_rise) begin
						nxt_st.out_sr = resp;
						nxt_st.err    = frame_err;
						nxt_st.ready  = 1'b0;
						if (!frame_err) begin
							nxt_st.start     = 1'b1;
							nxt_st.length    = is_write ? WR_LEN : RD_LEN;
							nxt_st.pend_wr   = is_write;
							nxt_st.pend_addr = addr;
							nxt_st.pend_data = wdata;
						end
					end else if (!st_ff.sel_b_s2 && sclk_rise) begin
						// shift in at the top, LSB first
						nxt_st.in_sr  = {st_ff.mosi_s2, st_ff.in_sr[15:1]};
						nxt_st.out_sr = {1'b0, st_ff.out_sr[15:1]};
						// outbound moves right after the rising edge, clock high
						nxt_st.miso   = st_ff.out_sr[1];
						if (st_ff.edge_cnt != `EDGE_CNT_MAX) begin
							nxt_st.edge_cnt = st_ff.edge_cnt + 5'h01;
						end
					end
				end
			end
			eeprom_spi_pkg::ST_RELOAD: begin
				nxt_st.fault_oe = 1'b1;
				if (!tif.busy && !st_ff.start && !tif.done) begin
					nxt_st.work  = st_ff.mem;
					nxt_st.state = eeprom_spi_pkg::ST_RUN;
				end
			end
			eeprom_spi_pkg::ST_RUN: begin
				nxt_st.fault_oe = 1'b0;
				if (!st_ff.en_s2) begin
					nxt_st.state = eeprom_spi_pkg::ST_SERIAL;
				end
			end
			default: begin
				nxt_st.state = eeprom_spi_pkg::ST_SERIAL;
			end
		endcase
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_ff          <= '0;
			st_ff.sel_b_s1 <= 1'b1;
			st_ff.sel_b_s2 <= 1'b1;
			st_ff.sel_b_s3 <= 1'b1;
			st_ff.mem      <= MEM_INIT;
			st_ff.work     <= MEM_INIT;
			st_ff.state    <= eeprom_spi_pkg::ST_SERIAL;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign low_side_input_one_o  = st_ff.miso;
	assign low_side_input_one_oe = st_ff.miso_oe;
	assign fault_comm_line_o     = 1'b0;
	assign fault_comm_line_oe    = st_ff.fault_oe;
	assign work_regs             = st_ff.work;
	assign reload_busy           = st_ff.fault_oe;

endmodule

/* File: rtl/eeprom_spi_pkg.sv */
// types of the serial configuration memory port
package eeprom_spi_pkg;

	// ----------------------------------------
	// command codes
	// ----------------------------------------
	typedef enum logic [1:0] {
		MEMORY_READ_CMD      = 2'h0,
		MEMORY_WRITE_CMD     = 2'h1,
		MEMORY_READ_ALT_CMD  = 2'h2,
		MEMORY_READ_ALT2_CMD = 2'h3
	} cmd_t;

	// ----------------------------------------
	// control states
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_SERIAL = 2'h0,
		ST_RELOAD = 2'h1,
		ST_RUN    = 2'h2
	} ctl_state_t;

	// ----------------------------------------
	// timer state
	// ----------------------------------------
	typedef struct packed {
		logic        busy;
		logic        done;
		logic [19:0] cnt;
	} timer_state_t;

	// ----------------------------------------
	// port state
	// ----------------------------------------
	typedef struct packed {
		logic        sclk_s1;
		logic        sclk_s2;
		logic        sclk_s3;
		logic        mosi_s1;
		logic        mosi_s2;
		logic        sel_b_s1;
		logic        sel_b_s2;
		logic        sel_b_s3;
		logic        en_s1;
		logic        en_s2;
		logic        en_s3;
		logic [15:0] in_sr;
		logic [15:0] out_sr;
		logic [4:0]  edge_cnt;
		logic        miso;
		logic        miso_oe;
		logic        fault_oe;
		logic        ready;
		logic        err;
		ctl_state_t  state;
		logic        start;
		logic [19:0] length;
		logic        pend_wr;
		logic [2:0]  pend_addr;
		logic [6:0]  pend_data;
		logic [7:0][6:0] mem;
		logic [7:0][6:0] work;
	} port_state_t;

endpackage

/* File: rtl/nvm_timer.sv */
// memory action timer: busy for a given count of cycles, then one done pulse
`include "eeprom_spi_cfg.svh"

module nvm_timer (
	// clock and reset
	input  wire logic   clk,
	input  wire logic   rst_b,
	// action handshake
	nvm_timer_if.timer  tif
);

	eeprom_spi_pkg::timer_state_t st_ff;
	eeprom_spi_pkg::timer_state_t nxt_st;

	always_comb begin
		nxt_st      = st_ff;
		nxt_st.done = 1'b0;
		if (tif.start) begin
			nxt_st.busy = 1'b1;
			nxt_st.cnt  = tif.length;
		end else if (st_ff.busy) begin
			if (st_ff.cnt <= 20'h00001) begin
				nxt_st.busy = 1'b0;
				nxt_st.done = 1'b1;
				nxt_st.cnt  = 20'h00000;
			end else begin
				nxt_st.cnt = st_ff.cnt - 20'h00001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign tif.busy = st_ff.busy;
	assign tif.done = st_ff.done;

endmodule

/* File: rtl/nvm_timer_if.sv */
// handshake between the serial port and the memory action timer
interface nvm_timer_if;
	logic        start;
	logic [19:0] length;
	logic        busy;
	logic        done;

	modport port (
		output start,
		output length,
		input  busy,
		input  done
	);

	modport timer (
		input  start,
		input  length,
		output busy,
		output done
	);
endinterface

/* File: tb/eeprom_spi_frame_access_chk.sv */
// pin level assertions for the serial memory port
module eeprom_spi_frame_access_chk #(
	parameter int unsigned READ_CYC  = 20,
	parameter int unsigned WRITE_CYC = 50
) (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        serial_mode,
	input wire logic        enable_pin,
	input wire logic        low_side_input_two,
	input wire logic        fault_comm_input,
	input wire logic        low_side_input_one_o,
	input wire logic        low_side_input_one_oe,
	input wire logic        fault_comm_line_o,
	input wire logic        fault_comm_line_oe,
	input wire logic [55:0] work_regs,
	input wire logic        reload_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0]  low_cnt_ff;
	logic [31:0] hold_cnt_ff;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// cycles of serial clock low inside a frame, and of reload hold
	always_ff @(posedge clk) begin
		low_cnt_ff <= (low_side_input_two || fault_comm_input) ? 4'h0 :
			low_cnt_ff + {3'h0, low_cnt_ff != 4'hF};
		hold_cnt_ff <= fault_comm_line_oe ? hold_cnt_ff + 32'h1 : 32'h0;
	end
	sequence s_enable_rise;
		$rose(enable_pin);
	endsequence
	sequence s_select_idle;
		fault_comm_input [*8];
	endsequence
	a_miso_hold_low: assert property (low_cnt_ff >= 4'h7 && low_side_input_one_oe |->
		$stable(low_side_input_one_o)) else $error("outbound bit moved while clock low");
	a_oe_after_select: assert property ($rose(low_side_input_one_oe) |->
		$past(!fault_comm_input, 3)) else $error("outbound driven without select");
	a_oe_select_idle: assert property (s_select_idle |-> !low_side_input_one_oe)
		else $error("outbound driven outside a frame");
	a_oe_mode_off: assert property (!serial_mode [*2] |-> !low_side_input_one_oe)
		else $error("outbound driven outside serial mode");
	a_reload_start: assert property (s_enable_rise |-> ##[2:8] fault_comm_line_oe)
		else $error("reload did not hold fault line");
	a_reload_bound: assert property (hold_cnt_ff <= WRITE_CYC + READ_CYC + 64)
		else $error("reload hold too long");
	a_fault_low: assert property (fault_comm_line_oe |-> !fault_comm_line_o)
		else $error("fault line not driven low");
	a_busy_match: assert property (reload_busy == fault_comm_line_oe)
		else $error("reload busy differs from fault hold");
	a_work_frozen: assert property (!fault_comm_line_oe && !$past(fault_comm_line_oe) |->
		$stable(work_regs)) else $error("working registers moved outside reload");
endmodule

bind eeprom_spi_frame_access eeprom_spi_frame_access_chk #(.READ_CYC(READ_CYC),
	.WRITE_CYC(WRITE_CYC)) i_chk (.clk(clk), .rst_b(rst_b), .serial_mode(serial_mode),
	.enable_pin(enable_pin), .low_side_input_two(low_side_input_two),
	.fault_comm_input(fault_comm_input), .low_side_input_one_o(low_side_input_one_o),
	.low_side_input_one_oe(low_side_input_one_oe), .fault_comm_line_o(fault_comm_line_o),
	.fault_comm_line_oe(fault_comm_line_oe), .work_regs(work_regs),
	.reload_busy(reload_busy));

/* File: tb/spi_master_model.sv */
// serial bus master driving the shared pins
module spi_master_model (
	input  wire logic clk,
	input  wire logic miso,
	output logic      sclk,
	output logic      mosi,
	output logic      sel_b
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] rx_word;
	logic        rx_done;
	initial begin
		sclk = 1'b0;
		mosi = 1'b0;
		sel_b = 1'b1;
		rx_done = 1'b0;
	end
	// n clock pulses, 160 ns period, then select high for gap cycles
	task automatic frame(input logic [15:0] tx, input int n, input int gap);
		sel_b <= 1'b0;
		repeat (16) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			mosi <= tx[i % 16];
			repeat (8) @(posedge clk);
			if (i < 16) rx_word[i] <= miso;
			sclk <= 1'b1;
			repeat (8) @(posedge clk);
			sclk <= 1'b0;
		end
		repeat (8) @(posedge clk);
		sel_b <= 1'b1;
		mosi <= ~mosi;
		rx_done <= 1'b1;
		@(posedge clk);
		rx_done <= 1'b0;
		repeat (gap) @(posedge clk);
	endtask
endmodule

/* File: tb/tb.sv */
// self-checking bench of the serial memory port
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int RC = 20;
	localparam int WC = 50;
	logic        clk = 1'b0;
	logic        rst_b, serial_mode, enable_pin, sclk, mosi, sel_b, miso_o, miso_oe;
	logic        fault_o, fault_oe, busy;
	logic [55:0] work_regs, w;
	logic [15:0] exp_q[$], msk_q[$], pend_e, pend_m;
	logic [6:0]  mem[8];
	logic        par_q[$], pend_p;
	int          failures = 0;
	int          cmp_count = 0;
	always #5 clk = ~clk;
	eeprom_spi_frame_access #(.READ_CYC(RC), .WRITE_CYC(WC)) i_dut (.clk(clk),
		.rst_b(rst_b), .serial_mode(serial_mode), .enable_pin(enable_pin),
		.low_side_input_two(sclk), .low_side_input_three(mosi), .fault_comm_input(sel_b),
		.low_side_input_one_o(miso_o), .low_side_input_one_oe(miso_oe),
		.fault_comm_line_o(fault_o), .fault_comm_line_oe(fault_oe), .work_regs(work_regs),
		.reload_busy(busy));
	spi_master_model i_mst (.clk(clk), .miso(miso_oe ? miso_o : ~miso_o), .sclk(sclk),
		.mosi(mosi), .sel_b(sel_b));
	task automatic check(input string what, input logic [55:0] seen, input logic [55:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// one frame; response noted for the frame after it
	task automatic op(input logic [1:0] c, input logic [2:0] a, input logic [6:0] d,
		input int n, input int gap, input logic bp);
		logic [15:0] f;
		exp_q.push_back(pend_e);
		msk_q.push_back(pend_m);
		par_q.push_back(pend_p && n >= 16);
		f = {1'b0, 2'($urandom), c, d, 1'b0, a};
		f[15] = ~^f[12:0] ^ bp;
		i_mst.frame(f, n, gap);
		pend_e = 16'h4000;
		pend_m = 16'h6000;
		pend_p = 1'b1;
		if (n == 16 && !bp) begin
			pend_e = {2'h0, gap >= ((c == 2'h1) ? WC : RC) + 12, c,
				(c == 2'h1) ? d : mem[a], 1'b0, a};
			pend_e[15] = ~^pend_e[14:0];
			pend_m = 16'hFFFF;
			if (c == 2'h1) mem[a] = d;
		end
	endtask
	always @(posedge clk) begin
		if (i_mst.rx_done && exp_q.size() > 0) begin
			check("response", i_mst.rx_word & msk_q[0], exp_q[0]);
			if (par_q[0]) check("parity", ^i_mst.rx_word, 1'b1);
			exp_q.pop_front();
			msk_q.pop_front();
			par_q.pop_front();
		end
	end
	task automatic wait_fault(input logic v);
		int i;
		for (i = 0; i < 300 && fault_oe !== v; i++) @(posedge clk);
		if (i == 300) begin
			failures++;
			final_report();
		end
	endtask
	initial begin
		rst_b = 1'b0;
		serial_mode = 1'b1;
		enable_pin = 1'b0;
		pend_e = 16'h0;
		pend_m = 16'h0;
		pend_p = 1'b0;
		foreach (mem[k]) mem[k] = 7'h00;
		void'($urandom(41));
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		repeat (6) @(posedge clk);
		for (int c = 0; c < 4; c++) op(2'(c), 3'($urandom), 7'($urandom), 16, 80, 1'b0);
		$display("test commands done");
		op(2'h1, 3'h5, 7'($urandom), 16, 80, 1'b0);
		repeat (3) op(2'h0, 3'h5, 7'h00, 16, 40, 1'b0);
		$display("test readback done");
		op(2'h1, 3'h5, 7'($urandom), 16, 80, 1'b1);
		op(2'h1, 3'h5, 7'($urandom), 15, 80, 1'b0);
		op(2'h1, 3'h5, 7'($urandom), 17, 80, 1'b0);
		op(2'h0, 3'h5, 7'h00, 16, 40, 1'b0);
		$display("test errors done");
		op(2'h2, 3'($urandom), 7'h00, 16, 8, 1'b0);
		op(2'h1, 3'h2, 7'($urandom), 16, 8, 1'b0);
		op(2'h3, 3'h2, 7'h00, 16, 40, 1'b0);
		op(2'h0, 3'h0, 7'h00, 16, 40, 1'b0);
		$display("test short gap done");
		enable_pin <= 1'b1;
		wait_fault(1'b1);
		wait_fault(1'b0);
		foreach (mem[k]) w[7*k +: 7] = mem[k];
		check("work_regs", work_regs, w);
		serial_mode <= 1'b0;
		repeat (4) @(posedge clk);
		$display("test reload done");
		final_report();
	end
endmodule
